// File: inc/rvr_pkg.sv
// Purpose: Constants for the regulator voltage register bank
// Assumes: 25 MHz clock, 8-bit register pointer and data
// Notes: Shared by the bank and its step-down ramp generator
//
// Overview of operation
// - Control bit 4 enables step-down voltage scaling
// - Control bits 3..0 pick ramp n+1 mV/us
// - Control register resets to 0x09
// - Control bits 7..5 reserved, host writes zero
// - Step-down code: 0.8 V plus 100 mV/step
// - Step-down code resets to 0x02, 1.0 V
// - Regulator one code: 1.6 V base, variant reset
// - Regulator two code: 1.2 V plus 100 mV/step
// - Regulator two code resets to 0x0E
// - Regulator three code: 1.6 V base, reset 0x11
package rvr_pkg;
    // Register pointers
    localparam logic [7:0] ADDR_SCALING_CTRL = 8'h03;
    localparam logic [7:0] ADDR_STEP_DOWN = 8'h04;
    localparam logic [7:0] ADDR_REG_ONE = 8'h05;
    localparam logic [7:0] ADDR_REG_TWO = 8'h06;
    localparam logic [7:0] ADDR_REG_THREE = 8'h07;
    // Scaling-control fields
    localparam int SCALING_ENABLE_BIT = 4;
    localparam int RAMP_CODE_MSB = 3;
    localparam int RAMP_CODE_LSB = 0;
    localparam logic [2:0] RESERVED_READ = 3'h0;
    // Reset values
    localparam logic [7:0] RESET_SCALING_CTRL = 8'h09;
    localparam logic [7:0] RESET_STEP_DOWN = 8'h02;
    localparam logic [7:0] RESET_REG_ONE = 8'h0c;
    localparam logic [7:0] RESET_REG_TWO = 8'h0e;
    localparam logic [7:0] RESET_REG_THREE = 8'h11;
    // Voltage scales in millivolts
    localparam logic [15:0] STEP_DOWN_BASE_MV = 16'h0320;
    localparam logic [15:0] REG_ONE_BASE_MV = 16'h0640;
    localparam logic [15:0] REG_TWO_BASE_MV = 16'h04b0;
    localparam logic [15:0] REG_THREE_BASE_MV = 16'h0640;
    localparam logic [15:0] CODE_STEP_MV = 16'h0064;
    // Highest listed codes
    localparam logic [7:0] MAX_STEP_DOWN = 8'h10;
    localparam logic [7:0] MAX_REG_ONE = 8'h11;
    localparam logic [7:0] MAX_REG_TWO = 8'h15;
    localparam logic [7:0] MAX_REG_THREE = 8'h11;
    localparam logic [3:0] MAX_RAMP_CODE = 4'hb;
    // Ramp timing: one slope step per microsecond
    localparam int CLK_PERIOD_NS = 40;
    localparam int RAMP_TICK_NS = 1000;
    localparam int RAMP_TICK_CYCLES = RAMP_TICK_NS / CLK_PERIOD_NS;
    localparam logic [15:0] RESET_STEP_DOWN_MV = 16'(STEP_DOWN_BASE_MV
        + CODE_STEP_MV * 16'(RESET_STEP_DOWN));
endpackage

// File: rtl/rvr_ramp.sv
// Purpose: Moves the step-down target toward its goal
// Assumes: One clock, synchronous active-low reset
// Notes: Steps once per microsecond by ramp code plus one mV
`timescale 1ns/1ns
module rvr_ramp (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scalingEnable,
    input wire logic [3:0] rampCode,
    input wire logic [15:0] goalMv,
    output logic [15:0] targetMv_r
);
    logic [4:0] tickCnt_r;
    logic tick;
    logic [15:0] stepMv;
    logic [15:0] targetMv_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Microsecond tick
    assign tick = (tickCnt_r == 5'(rvr_pkg::RAMP_TICK_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (!nrst || tick) begin
            tickCnt_r <= 5'h00;
        end else begin
            tickCnt_r <= tickCnt_r + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slope step and next target
    assign stepMv = {12'h000, rampCode} + 16'h0001;

    always_comb begin
        targetMv_nxt = targetMv_r;
        if (!scalingEnable) begin
            targetMv_nxt = goalMv; // Jump when scaling is off
        end else if (tick && targetMv_r < goalMv) begin
            if (goalMv - targetMv_r <= stepMv) begin
                targetMv_nxt = goalMv;
            end else begin
                targetMv_nxt = targetMv_r + stepMv;
            end
        end else if (tick && targetMv_r > goalMv) begin
            if (targetMv_r - goalMv <= stepMv) begin
                targetMv_nxt = goalMv;
            end else begin
                targetMv_nxt = targetMv_r - stepMv;
            end
        end
    end

    // Target register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            targetMv_r <= rvr_pkg::RESET_STEP_DOWN_MV;
        end else begin
            targetMv_r <= targetMv_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_ramp_hold;
        @(posedge clk) disable iff (!nrst)
        (scalingEnable && !tick) |=> $stable(targetMv_r) || !scalingEnable;
    endproperty
    a_ramp_hold: assert property (p_ramp_hold)
        else $error("target moved between ramp ticks");

    property p_ramp_bound;
        @(posedge clk) disable iff (!nrst)
        (scalingEnable && tick && $stable(rampCode)) |=>
            (!scalingEnable
            || (targetMv_r - $past(targetMv_r) <= $past(stepMv))
            || ($past(targetMv_r) - targetMv_r <= $past(stepMv)));
    endproperty
    a_ramp_bound: assert property (p_ramp_bound)
        else $error("ramp step larger than slope");

    property p_jump;
        @(posedge clk) disable iff (!nrst)
        !scalingEnable |=> targetMv_r == $past(goalMv);
    endproperty
    a_jump: assert property (p_jump)
        else $error("target did not follow goal with scaling off");
endmodule

// File: rtl/rvr_regs.sv
// Purpose: Voltage and scaling register bank behind the serial pointer
// Assumes: Serial slave presents pointer, strobes and byte on clk
// Notes: Read data appears one cycle after the read strobe
`timescale 1ns/1ns
module rvr_regs #(
    parameter logic [7:0] REG_ONE_RESET = rvr_pkg::RESET_REG_ONE
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData_r,
    output logic scalingEnable_r,
    output logic [3:0] stepDownRampCode_r,
    output logic [7:0] stepDownCode_r,
    output logic [7:0] regOneCode_r,
    output logic [7:0] regTwoCode_r,
    output logic [7:0] regThreeCode_r,
    output logic [15:0] stepDownTargetMv_r
);
    logic wrCtrl;
    logic wrStepDown;
    logic wrRegOne;
    logic wrRegTwo;
    logic wrRegThree;
    logic [7:0] ctrlRead;
    logic [7:0] regRdData_nxt;
    logic [15:0] stepDownGoalMv;

    ////////////////////////////////////////////////////////////////////////
    // Pointer decode
    assign wrCtrl = regWrEn && (regAddr == rvr_pkg::ADDR_SCALING_CTRL);
    assign wrStepDown = regWrEn && (regAddr == rvr_pkg::ADDR_STEP_DOWN);
    assign wrRegOne = regWrEn && (regAddr == rvr_pkg::ADDR_REG_ONE);
    assign wrRegTwo = regWrEn && (regAddr == rvr_pkg::ADDR_REG_TWO);
    assign wrRegThree = regWrEn && (regAddr == rvr_pkg::ADDR_REG_THREE);

    ////////////////////////////////////////////////////////////////////////
    // Scaling control: enable and ramp code, upper bits unused
    always_ff @(posedge clk) begin
        if (!nrst) begin
            scalingEnable_r <=
                rvr_pkg::RESET_SCALING_CTRL[rvr_pkg::SCALING_ENABLE_BIT];
            stepDownRampCode_r <= rvr_pkg::RESET_SCALING_CTRL[
                rvr_pkg::RAMP_CODE_MSB:rvr_pkg::RAMP_CODE_LSB];
        end else if (wrCtrl) begin
            scalingEnable_r <= regWrData[rvr_pkg::SCALING_ENABLE_BIT];
            stepDownRampCode_r <= regWrData[
                rvr_pkg::RAMP_CODE_MSB:rvr_pkg::RAMP_CODE_LSB];
        end
    end

    // Step-down code, stored as written
    always_ff @(posedge clk) begin
        if (!nrst) begin
            stepDownCode_r <= rvr_pkg::RESET_STEP_DOWN;
        end else if (wrStepDown) begin
            stepDownCode_r <= regWrData;
        end
    end

    // Regulator one code, variant reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            regOneCode_r <= REG_ONE_RESET;
        end else if (wrRegOne) begin
            regOneCode_r <= regWrData;
        end
    end

    // Regulator two code
    always_ff @(posedge clk) begin
        if (!nrst) begin
            regTwoCode_r <= rvr_pkg::RESET_REG_TWO;
        end else if (wrRegTwo) begin
            regTwoCode_r <= regWrData;
        end
    end

    // Regulator three code
    always_ff @(posedge clk) begin
        if (!nrst) begin
            regThreeCode_r <= rvr_pkg::RESET_REG_THREE;
        end else if (wrRegThree) begin
            regThreeCode_r <= regWrData;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path, reserved bits and unmapped pointers read zero
    assign ctrlRead = {rvr_pkg::RESERVED_READ, scalingEnable_r,
        stepDownRampCode_r};

    always_comb begin
        regRdData_nxt = 8'h00;
        unique case (regAddr)
            rvr_pkg::ADDR_SCALING_CTRL: regRdData_nxt = ctrlRead;
            rvr_pkg::ADDR_STEP_DOWN: regRdData_nxt = stepDownCode_r;
            rvr_pkg::ADDR_REG_ONE: regRdData_nxt = regOneCode_r;
            rvr_pkg::ADDR_REG_TWO: regRdData_nxt = regTwoCode_r;
            rvr_pkg::ADDR_REG_THREE: regRdData_nxt = regThreeCode_r;
            default: regRdData_nxt = 8'h00;
        endcase
    end

    // Read data holds until the next read strobe
    always_ff @(posedge clk) begin
        if (!nrst) begin
            regRdData_r <= 8'h00;
        end else if (regRdEn) begin
            regRdData_r <= regRdData_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Step-down goal in millivolts and its ramp
    assign stepDownGoalMv = 16'(rvr_pkg::STEP_DOWN_BASE_MV
        + rvr_pkg::CODE_STEP_MV * {8'h00, stepDownCode_r});

    rvr_ramp u_ramp (
        .clk(clk),
        .nrst(nrst),
        .scalingEnable(scalingEnable_r),
        .rampCode(stepDownRampCode_r),
        .goalMv(stepDownGoalMv),
        .targetMv_r(stepDownTargetMv_r)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    property p_enable_write;
        wrCtrl |=> scalingEnable_r ==
            $past(regWrData[rvr_pkg::SCALING_ENABLE_BIT]);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("scaling enable not taken from bit 4");

    property p_ramp_write;
        wrCtrl |=> stepDownRampCode_r ==
            $past(regWrData[rvr_pkg::RAMP_CODE_MSB:rvr_pkg::RAMP_CODE_LSB]);
    endproperty
    a_ramp_write: assert property (p_ramp_write)
        else $error("ramp code not taken from bits 3..0");

    property p_ctrl_reset;
        $rose(nrst) |-> ctrlRead == rvr_pkg::RESET_SCALING_CTRL;
    endproperty
    a_ctrl_reset: assert property (p_ctrl_reset)
        else $error("scaling control reset value wrong");

    property p_reserved_zero;
        (regRdEn && regAddr == rvr_pkg::ADDR_SCALING_CTRL) |=>
            regRdData_r[7:5] == 3'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved control bits read nonzero");

    property p_code_store;
        wrStepDown ##1 !wrStepDown [*2] |-> stepDownCode_r ==
            $past(regWrData, 2);
    endproperty
    a_code_store: assert property (p_code_store)
        else $error("step-down code not stored unchanged");

    property p_code_readback;
        (regRdEn && regAddr == rvr_pkg::ADDR_STEP_DOWN && !regWrEn) |=>
            regRdData_r == stepDownCode_r;
    endproperty
    a_code_readback: assert property (p_code_readback)
        else $error("step-down readback mismatch");

    property p_codes_reset;
        $rose(nrst) |-> stepDownCode_r == rvr_pkg::RESET_STEP_DOWN
            && stepDownTargetMv_r == rvr_pkg::RESET_STEP_DOWN_MV;
    endproperty
    a_codes_reset: assert property (p_codes_reset)
        else $error("step-down reset value wrong");

    property p_one_reset;
        $rose(nrst) |-> regOneCode_r == REG_ONE_RESET;
    endproperty
    a_one_reset: assert property (p_one_reset)
        else $error("regulator one reset value wrong");

    property p_two_reset;
        $rose(nrst) |-> regTwoCode_r == rvr_pkg::RESET_REG_TWO;
    endproperty
    a_two_reset: assert property (p_two_reset)
        else $error("regulator two reset value wrong");

    property p_three_reset;
        $rose(nrst) |-> regThreeCode_r == rvr_pkg::RESET_REG_THREE;
    endproperty
    a_three_reset: assert property (p_three_reset)
        else $error("regulator three reset value wrong");

    property p_two_write;
        wrRegTwo |=> regTwoCode_r == $past(regWrData);
    endproperty
    a_two_write: assert property (p_two_write)
        else $error("regulator two code not stored");

    property p_one_write;
        wrRegOne |=> regOneCode_r == $past(regWrData);
    endproperty
    a_one_write: assert property (p_one_write)
        else $error("regulator one code not stored");

    property p_three_write;
        wrRegThree |=> regThreeCode_r == $past(regWrData);
    endproperty
    a_three_write: assert property (p_three_write)
        else $error("regulator three code not stored");

    property p_step_write;
        wrStepDown |=> stepDownCode_r == $past(regWrData);
    endproperty
    a_step_write: assert property (p_step_write)
        else $error("step-down code not stored");

    property p_ctrl_readback;
        (regRdEn && regAddr == rvr_pkg::ADDR_SCALING_CTRL && !regWrEn) |=>
            regRdData_r[rvr_pkg::SCALING_ENABLE_BIT] == scalingEnable_r
            && regRdData_r[rvr_pkg::RAMP_CODE_MSB:rvr_pkg::RAMP_CODE_LSB]
            == stepDownRampCode_r;
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback)
        else $error("scaling control readback mismatch");
endmodule

// File: testbench/rvr_host.sv
// Purpose: Serial-slave side model issuing register bytes
// Assumes: Strobes driven at the falling edge of clk
// Notes: Released pointer and data show inverted values
`timescale 1ns/1ns
module rvr_host (
    input wire logic clk,
    input wire logic [7:0] regRdData_r,
    output logic regWrEn,
    output logic regRdEn,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData
);
    // Idle bus at time zero
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end
    // One-cycle write strobe; caller picks codes
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge clk);
        regWrEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
    endtask
    // One-cycle read strobe, byte taken a cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        regRdEn = 1'b1;
        regAddr = a;
        @(negedge clk);
        d = regRdData_r;
        regRdEn = 1'b0;
        regAddr = ~a;
    endtask
endmodule

// File: testbench/rvr_regs_tb.sv
// Purpose: Self-checking bench for the voltage register bank
// Assumes: Default variant reset for regulator one
// Notes: Scaling ramp watched through the target output
`timescale 1ns/1ns
module rvr_regs_tb;
    logic clk;
    logic nrst;
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
    logic [7:0] rdData;
    logic scalEn;
    logic [3:0] ramp;
    logic [7:0] sdCode;
    logic [7:0] oneCode;
    logic [7:0] twoCode;
    logic [7:0] threeCode;
    logic [15:0] tgt;
    int n_fail;
    int n_compared;
    rvr_regs dut_u (.clk(clk), .nrst(nrst), .regWrEn(wrEn),
        .regRdEn(rdEn), .regAddr(addr), .regWrData(wrData),
        .regRdData_r(rdData), .scalingEnable_r(scalEn),
        .stepDownRampCode_r(ramp), .stepDownCode_r(sdCode),
        .regOneCode_r(oneCode), .regTwoCode_r(twoCode),
        .regThreeCode_r(threeCode), .stepDownTargetMv_r(tgt));
    rvr_host host_u (.clk(clk), .regRdData_r(rdData), .regWrEn(wrEn),
        .regRdEn(rdEn), .regAddr(addr), .regWrData(wrData));
    ////////////////////////////////////////////////////////////////
    // Clock at 40 ns
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Compare bytes
    task automatic check8(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t: byte %h expected %h", $time, g, e);
        end
    endtask
    // Compare millivolt values
    task automatic check16(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %0t: mV %h expected %h", $time, g, e);
        end
    endtask
    task automatic finish_test;
        if (n_fail == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Read one register and compare
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        host_u.rd(a, d);
        check8(d, e);
    endtask
    ////////////////////////////////////////////////////////////////
    // Values after reset, unmapped pointer reads zero
    task automatic test_reset;
        check8({3'h0, scalEn, ramp}, 8'h09);
        rdchk(8'h03, 8'h09);
        rdchk(8'h04, 8'h02);
        check16(tgt, 16'h03e8);
        rdchk(8'h05, rvr_pkg::RESET_REG_ONE);
        rdchk(8'h06, 8'h0e);
        rdchk(8'h07, 8'h11);
        rdchk(8'h08, 8'h00);
    endtask
    // Ramp codes 0 to 11 with scaling on, then reserved bits only
    task automatic test_ctrl;
        logic [3:0] c;
        for (int i = 0; i <= 11; i++) begin
            c = 4'(i);
            host_u.wr(8'h03, {3'h0, 1'b1, c});
            check8({3'h0, scalEn, ramp}, {4'h1, c});
            rdchk(8'h03, {3'h0, 1'b1, c});
        end
        host_u.wr(8'h03, 8'he0);
        rdchk(8'h03, 8'h00);
    endtask
    // Top listed codes, out-of-range code kept as written
    task automatic test_codes;
        host_u.wr(8'h04, 8'h10);
        @(negedge clk);
        check16(tgt, 16'h0960);
        host_u.wr(8'h05, 8'h11);
        host_u.wr(8'h06, 8'h15);
        host_u.wr(8'h07, 8'h11);
        host_u.wr(8'h08, 8'h55);
        check8(sdCode, 8'h10);
        check8(oneCode, 8'h11);
        check8(twoCode, 8'h15);
        check8(threeCode, 8'h11);
        host_u.wr(8'h06, 8'hff);
        rdchk(8'h06, 8'hff);
    endtask
    // Follow the target to its goal, one slope step per microsecond
    task automatic ramp_watch(input logic [15:0] goal,
        input logic [15:0] step, input int nSteps);
        logic [15:0] prev;
        logic [15:0] expMv;
        int n;
        int steps;
        int gap;
        prev = tgt;
        steps = 0;
        gap = 0;
        for (n = 0; n < 400 && tgt !== goal; n++) begin
            @(negedge clk);
            gap++;
            if (tgt !== prev) begin
                if (goal > prev) begin
                    expMv = (goal - prev > step) ? prev + step : goal;
                end else begin
                    expMv = (prev - goal > step) ? prev - step : goal;
                end
                check16(tgt, expMv);
                if (steps > 0) begin
                    check16(16'(gap), 16'(rvr_pkg::RAMP_TICK_CYCLES));
                end
                prev = tgt;
                steps++;
                gap = 0;
            end
        end
        if (tgt !== goal) begin
            n_fail++;
            $display("ERROR %0t: ramp did not settle", $time);
            finish_test();
        end else begin
            check16(16'(steps), 16'(nSteps));
        end
    endtask
    // Scaling on: 1.0 V up to 1.1 V by 10 mV, back down by 12 mV
    task automatic test_ramp;
        host_u.wr(8'h04, 8'h02);
        @(negedge clk);
        check16(tgt, 16'h03e8);
        host_u.wr(8'h03, 8'h19);
        host_u.wr(8'h04, 8'h03);
        ramp_watch(16'h044c, 16'h000a, 10);
        host_u.wr(8'h03, 8'h1b);
        host_u.wr(8'h04, 8'h02);
        ramp_watch(16'h03e8, 16'h000c, 9);
    endtask
    ////////////////////////////////////////////////////////////////
    // Reset for three cycles, then run the scenarios
    initial begin
        n_fail = 0;
        n_compared = 0;
        nrst = 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        test_reset();
        test_ctrl();
        test_codes();
        test_ramp();
        finish_test();
    end
endmodule
